// File: atsq_arm_trigger_sequencer.sv
// Arm/trigger sequencer of one channel with its register port.
`timescale 1ns/100ps
// Overview of operation
// R1 - Initiate takes an idle sequencer into the arm layer.
// R2 - Arm event from chosen source, then arm delay, leads to trigger layer.
// R3 - Each trigger event, after trigger delay, runs the action once.
// R4 - Trigger loop repeats to trigger count, then back to arm layer.
// R5 - Arm loop repeats to arm count, then back to idle.
// R6 - Separate sequencers for source output and measurement, started apart.
// R7 - Arm and trigger sources are chosen separately per sequencer.
// R8 - Sources: automatic, bus, timer, two internal lines, LAN, 14 DIGITAL_IO_PORT lines.
// R9 - Timer source raises an event every programmed period.
// R10 - A source action applies one value after the source delay.
// R11 - A measure action takes one result after the measure delay.
// R12 - Automatic mode with output on measures repeatedly; source stays idle.
// R13 - Trigger output points: entry and exit of arm, trigger, action.
// R14 - Each point has an enable and a before/after timing choice.
// R15 - Trigger output goes to an internal line, LAN or a DIGITAL_IO_PORT line.
// R16 - Grouped: source in channel order, measure together, hold output.
// R17 - Ungrouped channels sequence without looking at each other.
// R18 - Grouping needs equal sources, and equal timer period beyond count 1.
// R19 - Wait time blocks actions; grouped, it starts at last output change.
// R20 - Equal settings and no wait make both channels start together.
// R21 - DIGITAL_IO_PORT trigger pulses default to both timings and 100 us width.
// R22 - Trigger counter clears on trigger entry, arm counter on initiate.
// R23 - Delays and timer period count ticks of a fixed timebase.
module atsq_arm_trigger_sequencer
  import atsq_pkg::*;
#(
  parameter int PULSE_CYCLES = PULSE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  input wire logic busTrig,
  input wire logic lanTrigIn,
  input wire logic [1:0] intLineIn,
  input wire logic [DIO_LINES-1:0] dioIn,
  input wire logic sourceDone,
  input wire logic measureDone,
  input wire logic chanSecond,
  input wire logic peerSourced,
  output logic sourceApply,
  output logic measureStart,
  output logic sourceHeld,
  output logic [1:0] intLineOut,
  output logic lanTrigOut,
  output logic [DIO_LINES-1:0] dioOut,
  output logic [DIO_LINES-1:0] dioOeN
);
  typedef struct packed {
    atsq_cfg_t [SEQS-1:0] cfg;
    atsq_seq_t [SEQS-1:0] seq;
    logic autoMode;
    logic group;
    logic outputOn;
    logic waitEn;
    logic [15:0] waitTime;
    logic [15:0] waitCnt;
    logic waiting;
    logic sourced;
    logic allPrev;
    logic srcApply;
    logic measStart;
    logic [PIN_LINES-1:0] pin1;
    logic [PIN_LINES-1:0] pin2;
    logic [PIN_LINES-1:0] pin3;
    logic [DIO_LINES-1:0] dioOeN;
    logic [31:0] rdData;
  } atsq_top_t;

  atsq_top_t st_r, st_nxt;
  logic tick;
  logic ctrlWr;
  logic abortReq;
  logic autoOn;
  logic [SEQS-1:0] initReq;

  atsq_fire_if fif();

  atsq_tick u_tick (
    .clk(clk),
    .resetn(resetn),
    .tick(tick)
  );

  atsq_pulse #(
    .WIDTH_CYC(PULSE_CYCLES)
  ) u_pulse (
    .clk(clk),
    .resetn(resetn),
    .fif(fif.pulser)
  );

  function automatic logic srcHit(input logic [4:0] code,
      input logic [EVT_CODES-1:0] ev);
    srcHit = (code < 5'(EVT_CODES)) ? ev[code] : 1'b0;
  endfunction

  // A count of zero behaves as one, so a loop always runs at least once.
  function automatic logic isLast(input logic [15:0] n,
      input logic [15:0] count);
    isLast = ((n + 16'h0001) >= count);
  endfunction

  function automatic logic [15:0] stepDown(input logic [15:0] v,
      input logic tk);
    stepDown = (tk && v != 16'h0000) ? v - 16'h0001 : v;
  endfunction

  function automatic logic [31:0] cfgRead(input atsq_cfg_t c,
      input logic [2:0] idx);
    cfgRead = '0;
    unique case (idx)
      IDX_SRC: begin
        cfgRead[SRC_ARM_LSB +: 5] = c.armSrc;
        cfgRead[SRC_TRG_LSB +: 5] = c.trgSrc;
      end
      IDX_ARMCNT: cfgRead[15:0] = c.armCount;
      IDX_TRGCNT: cfgRead[15:0] = c.trgCount;
      IDX_ARMDLY: cfgRead[15:0] = c.armDelay;
      IDX_TRGDLY: cfgRead[15:0] = c.trgDelay;
      IDX_ACTDLY: cfgRead[15:0] = c.actDelay;
      IDX_PERIOD: cfgRead[15:0] = c.period;
      IDX_OUTCFG: begin
        cfgRead[OCFG_TIMING_LSB +: 6] = c.timing;
        cfgRead[OCFG_EN_LSB +: 3] = c.outEn;
        cfgRead[OCFG_DST_LSB +: 5] = c.dest;
      end
    endcase
  endfunction

  function automatic atsq_cfg_t cfgWrite(input atsq_cfg_t c,
      input logic [2:0] idx, input logic [31:0] d);
    cfgWrite = c;
    unique case (idx)
      IDX_SRC: begin
        cfgWrite.armSrc = d[SRC_ARM_LSB +: 5]; // R7
        cfgWrite.trgSrc = d[SRC_TRG_LSB +: 5]; // R7
      end
      IDX_ARMCNT: cfgWrite.armCount = d[15:0];
      IDX_TRGCNT: cfgWrite.trgCount = d[15:0];
      IDX_ARMDLY: cfgWrite.armDelay = d[15:0];
      IDX_TRGDLY: cfgWrite.trgDelay = d[15:0];
      IDX_ACTDLY: cfgWrite.actDelay = d[15:0];
      IDX_PERIOD: cfgWrite.period = d[15:0];
      IDX_OUTCFG: begin
        cfgWrite.timing = d[OCFG_TIMING_LSB +: 6]; // R14
        cfgWrite.outEn = d[OCFG_EN_LSB +: 3]; // R14
        cfgWrite.dest = d[OCFG_DST_LSB +: 5]; // R15
      end
    endcase
  endfunction

  assign ctrlWr = wrStrobe && (addr == OFS_CTRL);
  assign abortReq = ctrlWr && wrData[CTRL_ABORT];
  assign initReq[0] = ctrlWr && wrData[CTRL_INIT_SOURCE]; // R6
  assign initReq[1] = ctrlWr && wrData[CTRL_INIT_MEASURE]; // R6
  assign autoOn = st_r.autoMode && st_r.outputOn;

  always_comb begin
    atsq_cfg_t ec;
    logic [EVT_CODES-1:0] ev;
    logic [PIN_LINES-1:0] rise;
    logic [OUT_LINES-1:0] fireVec;
    logic [5:0] pts;
    logic [5:0] ptMask;
    logic [31:0] rd;
    logic tmrHit;
    logic gate;
    logic done;
    logic allNow;
    logic sel;
    ec = '0;
    ev = '0;
    pts = '0;
    ptMask = '0;
    rd = '0;
    tmrHit = 1'b0;
    gate = 1'b0;
    done = 1'b0;
    fireVec = '0;
    sel = (addr[7:5] == PAGE_MEASURE);
    st_nxt = st_r;
    st_nxt.srcApply = 1'b0;
    st_nxt.measStart = 1'b0;
    st_nxt.rdData = '0;
    st_nxt.pin1 = {dioIn, intLineIn};
    st_nxt.pin2 = st_r.pin1;
    st_nxt.pin3 = st_r.pin2;
    rise = st_r.pin2 & ~st_r.pin3;

    if (wrStrobe) begin
      if (ctrlWr) begin
        st_nxt.autoMode = wrData[CTRL_AUTO];
        st_nxt.group = wrData[CTRL_GROUP];
        st_nxt.outputOn = wrData[CTRL_OUTPUT_ON];
        st_nxt.waitEn = wrData[CTRL_WAIT_EN];
      end else if (addr == OFS_WAIT) begin
        st_nxt.waitTime = wrData[15:0];
      end else if (addr[7:5] == PAGE_SOURCE || sel) begin
        st_nxt.cfg[sel] = cfgWrite(st_r.cfg[sel], addr[4:2], wrData);
      end
    end
    if (rdStrobe) begin
      if (addr == OFS_CTRL) begin
        rd[CTRL_AUTO] = st_r.autoMode;
        rd[CTRL_GROUP] = st_r.group;
        rd[CTRL_OUTPUT_ON] = st_r.outputOn;
        rd[CTRL_WAIT_EN] = st_r.waitEn;
      end else if (addr == OFS_WAIT) begin
        rd[15:0] = st_r.waitTime;
      end else if (addr == OFS_STATUS) begin
        rd[STAT_SOURCE_LSB +: 3] = st_r.seq[0].st;
        rd[STAT_MEASURE_LSB +: 3] = st_r.seq[1].st;
        rd[STAT_WAITING] = st_r.waiting;
        rd[STAT_SOURCED] = st_r.sourced;
      end else if (addr[7:5] == PAGE_SOURCE || sel) begin
        rd = cfgRead(st_r.cfg[sel], addr[4:2]);
      end
      st_nxt.rdData = rd;
    end

    // The wait starts once the last output of the group has changed.
    allNow = st_r.sourced && (!st_r.group || peerSourced); // R19
    st_nxt.allPrev = allNow;
    if (st_r.waitEn && allNow && !st_r.allPrev) begin
      st_nxt.waiting = 1'b1; // R19
      st_nxt.waitCnt = st_r.waitTime;
    end else if (st_r.waiting) begin
      st_nxt.waitCnt = stepDown(st_r.waitCnt, tick);
      st_nxt.waiting = (st_r.waitCnt != 16'h0000);
    end

    for (int i = 0; i < SEQS; i++) begin
      ec = st_r.cfg[i];
      pts = '0;
      if (autoOn && i == 1) begin
        ec.armSrc = SRC_AUTOMATIC_SOURCE; // R12
        ec.trgSrc = SRC_AUTOMATIC_SOURCE;
        ec.armCount = COUNT_RST;
        ec.trgCount = COUNT_RST;
        ec.armDelay = '0;
        ec.trgDelay = '0;
      end
      tmrHit = tick && (st_r.seq[i].st != ST_IDLE) &&
               (st_r.seq[i].tmr <= 16'h0001); // R9
      if (st_r.seq[i].st == ST_IDLE) begin
        st_nxt.seq[i].tmr = ec.period;
      end else if (tick) begin
        st_nxt.seq[i].tmr = tmrHit ? ec.period
                                   : st_r.seq[i].tmr - 16'h0001; // R23
      end
      ev = {rise[PIN_LINES-1:2], lanTrigIn, rise[1], rise[0],
            tmrHit, busTrig, 1'b1}; // R8
      if (i == 0) begin
        gate = !st_r.waiting &&
               (!st_r.group || !chanSecond || peerSourced); // R16
        done = st_r.sourced && (!st_r.group || measureDone); // R16
      end else begin
        gate = !st_r.waiting &&
               (!st_r.group || (st_r.sourced && peerSourced)); // R16
        done = measureDone;
      end
      unique case (st_r.seq[i].st)
        ST_IDLE: begin
          if (initReq[i] || (autoOn && i == 1)) begin
            st_nxt.seq[i].st = ST_ARM_WAIT; // R1
            st_nxt.seq[i].armN = '0; // R22
            pts[0] = 1'b1;
          end
        end
        ST_ARM_WAIT: begin
          if (srcHit(ec.armSrc, ev)) begin
            st_nxt.seq[i].st = ST_ARM_DELAY; // R2
            st_nxt.seq[i].dly = ec.armDelay;
          end
        end
        ST_ARM_DELAY: begin
          st_nxt.seq[i].dly = stepDown(st_r.seq[i].dly, tick);
          if (st_r.seq[i].dly == 16'h0000) begin
            st_nxt.seq[i].st = ST_TRG_WAIT; // R2
            st_nxt.seq[i].trgN = '0; // R22
            pts[2:1] = 2'b11;
          end
        end
        ST_TRG_WAIT: begin
          if (srcHit(ec.trgSrc, ev)) begin
            st_nxt.seq[i].st = ST_TRG_DELAY; // R3
            st_nxt.seq[i].dly = ec.trgDelay;
          end
        end
        ST_TRG_DELAY: begin
          st_nxt.seq[i].dly = stepDown(st_r.seq[i].dly, tick);
          if (st_r.seq[i].dly == 16'h0000) begin
            st_nxt.seq[i].st = ST_ACT_DELAY; // R3
            st_nxt.seq[i].dly = ec.actDelay;
          end
        end
        ST_ACT_DELAY: begin
          st_nxt.seq[i].dly = stepDown(st_r.seq[i].dly, tick);
          if (st_r.seq[i].dly == 16'h0000) begin
            st_nxt.seq[i].st = ST_ACT_GATE;
          end
        end
        ST_ACT_GATE: begin
          // Each sequencer leaves here on the cycle its gate opens; grouped, the second channel's source waits for peerSourced. No tick is needed.
          if (gate) begin
            st_nxt.seq[i].st = ST_ACT_RUN; // R20
            pts[4] = 1'b1;
            if (i == 0) begin
              st_nxt.srcApply = 1'b1; // R10
            end else begin
              st_nxt.measStart = 1'b1; // R11
            end
          end
        end
        ST_ACT_RUN: begin
          if (done) begin
            pts[5] = 1'b1;
            st_nxt.seq[i].trgN = st_r.seq[i].trgN + 16'h0001;
            st_nxt.seq[i].st = ST_TRG_WAIT;
            if (isLast(st_r.seq[i].trgN, ec.trgCount)) begin
              pts[3] = 1'b1; // R4
              st_nxt.seq[i].armN = st_r.seq[i].armN + 16'h0001;
              st_nxt.seq[i].st = ST_ARM_WAIT; // R4
              pts[0] = 1'b1;
              if (isLast(st_r.seq[i].armN, ec.armCount)) begin
                st_nxt.seq[i].st = ST_IDLE; // R5
                pts[0] = 1'b0;
              end
            end
          end
        end
      endcase
      if (abortReq || (autoOn && i == 0)) begin
        st_nxt.seq[i].st = ST_IDLE; // R12
        pts = '0;
        if (i == 0) begin
          st_nxt.srcApply = 1'b0;
        end else begin
          st_nxt.measStart = 1'b0;
        end
      end
      ptMask = {{2{ec.outEn[2]}}, {2{ec.outEn[1]}}, {2{ec.outEn[0]}}};
      ptMask = ptMask & ec.timing; // R14
      for (int k = 0; k < OUT_LINES; k++) begin
        if (|(pts & ptMask) && ec.dest == 5'(k)) begin
          fireVec[k] = 1'b1; // R13
        end
      end
    end

    // The clears below give way to a source change in the same cycle.
    if (measureDone || st_r.seq[0].st == ST_IDLE ||
        (st_r.seq[0].st == ST_ACT_RUN && done)) begin
      st_nxt.sourced = 1'b0;
    end
    if (sourceDone && st_r.seq[0].st == ST_ACT_RUN && !st_r.sourced) begin
      st_nxt.sourced = 1'b1; // R16
    end

    for (int d = 0; d < DIO_LINES; d++) begin
      st_nxt.dioOeN[d] = 1'b1;
      for (int j = 0; j < SEQS; j++) begin
        if (st_r.cfg[j].outEn != 3'h0 &&
            st_r.cfg[j].dest == DST_DIGITAL_IO_LINE_FIRST + 5'(d)) begin
          st_nxt.dioOeN[d] = 1'b0; // R15
        end
      end
    end

    if (!resetn) begin
      st_nxt = '0;
      st_nxt.dioOeN = '1;
      for (int i = 0; i < SEQS; i++) begin
        st_nxt.cfg[i].armCount = COUNT_RST;
        st_nxt.cfg[i].trgCount = COUNT_RST;
        st_nxt.cfg[i].period = PERIOD_RST;
        st_nxt.cfg[i].timing = TIMING_RST; // R21
      end
    end
    fif.fire = fireVec;
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign rdData = st_r.rdData;
  assign sourceApply = st_r.srcApply;
  assign measureStart = st_r.measStart;
  assign sourceHeld = st_r.sourced;
  assign dioOeN = st_r.dioOeN;
  assign intLineOut = fif.level[1:0];
  assign lanTrigOut = fif.level[2];
  assign dioOut = fif.level[OUT_LINES-1:3];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_quiet;
    !abortReq && !autoOn;
  endsequence
  sequence s_arm_delay_over;
    st_r.seq[1].st == ST_ARM_DELAY && st_r.seq[1].dly == 16'h0000;
  endsequence
  sequence s_trig_entry;
    st_r.seq[1].st == ST_TRG_WAIT && st_r.seq[1].trgN == 16'h0000;
  endsequence
  sequence s_meas_done_run;
    st_r.seq[1].st == ST_ACT_RUN && measureDone;
  endsequence

  a_init_to_arm: assert property ( // R1
    (st_r.seq[0].st == ST_IDLE && initReq[0]) and s_quiet |=>
      st_r.seq[0].st == ST_ARM_WAIT && st_r.seq[0].armN == 16'h0000)
    else $error("Initiate did not enter the arm layer.");
  a_arm_needs_event: assert property ( // R2
    (st_r.seq[0].st == ST_ARM_WAIT && st_r.cfg[0].armSrc == SRC_BUS &&
     !busTrig) and s_quiet |=> st_r.seq[0].st == ST_ARM_WAIT)
    else $error("Arm layer left without an arm event.");
  a_trig_counter_clear: assert property ( // R22
    s_arm_delay_over and s_quiet |=> s_trig_entry)
    else $error("Trigger layer entered without clearing its count.");
  a_source_pulse_once: assert property ( // R10
    st_r.srcApply |=> !st_r.srcApply ##1 !st_r.srcApply)
    else $error("Source apply pulse repeated.");
  a_meas_pulse_cause: assert property ( // R11
    $rose(st_r.measStart) |-> st_r.seq[1].st == ST_ACT_RUN)
    else $error("Measure start without entering the action.");
  a_trig_loop_back: assert property ( // R4
    (s_meas_done_run and s_quiet) ##0
    (isLast(st_r.seq[1].trgN, st_r.cfg[1].trgCount) &&
     !isLast(st_r.seq[1].armN, st_r.cfg[1].armCount)) |=>
      st_r.seq[1].st == ST_ARM_WAIT)
    else $error("Trigger loop did not return to the arm layer.");
  a_arm_loop_idle: assert property ( // R5
    (s_meas_done_run and s_quiet) ##0
    (isLast(st_r.seq[1].trgN, st_r.cfg[1].trgCount) &&
     isLast(st_r.seq[1].armN, st_r.cfg[1].armCount)) |=>
      st_r.seq[1].st == ST_IDLE)
    else $error("Arm loop did not return to idle.");
  a_auto_no_source: assert property ( // R12
    autoOn |=> !st_r.srcApply && st_r.seq[0].st == ST_IDLE)
    else $error("Source action ran in automatic mode.");
  a_group_order: assert property ( // R16
    st_r.group && chanSecond && !peerSourced &&
    st_r.seq[0].st == ST_ACT_GATE |=> !st_r.srcApply)
    else $error("Second channel sourced before the first.");
  a_wait_blocks_act: assert property ( // R19
    st_r.waiting |=> !st_r.measStart && !st_r.srcApply)
    else $error("Action started during the wait time.");
  a_ungrouped_free: assert property ( // R17
    (!st_r.group && !st_r.waiting && st_r.seq[1].st == ST_ACT_GATE)
    and s_quiet |=> st_r.measStart)
    else $error("Ungrouped measurement was held back.");
endmodule // atsq_arm_trigger_sequencer

// File: atsq_pkg.sv
// Shared constants and types of the arm/trigger sequencer.
package atsq_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_WIDTH_US = 100;
  localparam int PULSE_CYC = PULSE_WIDTH_US * 1000 / CLK_PERIOD_NS;
  localparam int SEQS = 2;
  localparam int DIO_LINES = 14;
  localparam int PIN_LINES = DIO_LINES + 2;
  localparam int OUT_LINES = DIO_LINES + 3;
  localparam int EVT_CODES = DIO_LINES + 6;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WAIT = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [2:0] PAGE_SOURCE = 3'h1;
  localparam logic [2:0] PAGE_MEASURE = 3'h2;
  localparam logic [2:0] IDX_SRC = 3'h0;
  localparam logic [2:0] IDX_ARMCNT = 3'h1;
  localparam logic [2:0] IDX_TRGCNT = 3'h2;
  localparam logic [2:0] IDX_ARMDLY = 3'h3;
  localparam logic [2:0] IDX_TRGDLY = 3'h4;
  localparam logic [2:0] IDX_ACTDLY = 3'h5;
  localparam logic [2:0] IDX_PERIOD = 3'h6;
  localparam logic [2:0] IDX_OUTCFG = 3'h7;
  localparam int CTRL_INIT_SOURCE = 0;
  localparam int CTRL_INIT_MEASURE = 1;
  localparam int CTRL_ABORT = 2;
  localparam int CTRL_AUTO = 3;
  localparam int CTRL_GROUP = 4;
  localparam int CTRL_OUTPUT_ON = 5;
  localparam int CTRL_WAIT_EN = 6;
  localparam int SRC_ARM_LSB = 0;
  localparam int SRC_TRG_LSB = 8;
  localparam int OCFG_TIMING_LSB = 0;
  localparam int OCFG_EN_LSB = 8;
  localparam int OCFG_DST_LSB = 16;
  localparam int STAT_SOURCE_LSB = 0;
  localparam int STAT_MEASURE_LSB = 4;
  localparam int STAT_WAITING = 8;
  localparam int STAT_SOURCED = 9;
  localparam logic [4:0] SRC_AUTOMATIC_SOURCE = 5'h00;
  localparam logic [4:0] SRC_BUS = 5'h01;
  localparam logic [4:0] SRC_TIMER = 5'h02;
  localparam logic [4:0] SRC_INTERNAL_LINE_ONE = 5'h03;
  localparam logic [4:0] SRC_INTERNAL_LINE_TWO = 5'h04;
  localparam logic [4:0] SRC_LAN = 5'h05;
  localparam logic [4:0] SRC_DIGITAL_IO_LINE_FIRST = 5'h06;
  localparam logic [4:0] DST_DIGITAL_IO_LINE_FIRST = 5'h03;
  localparam logic [15:0] COUNT_RST = 16'h0001;
  localparam logic [15:0] PERIOD_RST = 16'h0001;
  localparam logic [5:0] TIMING_RST = 6'h3F;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARM_WAIT, ST_ARM_DELAY, ST_TRG_WAIT,
    ST_TRG_DELAY, ST_ACT_DELAY, ST_ACT_GATE, ST_ACT_RUN
  } atsq_state_t;
  typedef struct packed {
    logic [4:0] armSrc;
    logic [4:0] trgSrc;
    logic [15:0] armCount;
    logic [15:0] trgCount;
    logic [15:0] armDelay;
    logic [15:0] trgDelay;
    logic [15:0] actDelay;
    logic [15:0] period;
    logic [5:0] timing;
    logic [2:0] outEn;
    logic [4:0] dest;
  } atsq_cfg_t;
  typedef struct packed {
    atsq_state_t st;
    logic [15:0] armN;
    logic [15:0] trgN;
    logic [15:0] dly;
    logic [15:0] tmr;
  } atsq_seq_t;
endpackage

// File: atsq_fire_if.sv
// Fire requests and line levels between sequencer and pulse shaper.
`timescale 1ns/100ps
interface atsq_fire_if;
  import atsq_pkg::*;
  logic [OUT_LINES-1:0] fire;
  logic [OUT_LINES-1:0] level;
  modport seqr (output fire, input level);
  modport pulser (input fire, output level);
endinterface // atsq_fire_if

// File: atsq_tick.sv
// Microsecond timebase that paces every delay and timer count.
`timescale 1ns/100ps
module atsq_tick
  import atsq_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  output logic tick
);
  localparam int CW = $clog2(TICK_CYC);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic tick;
  } atsq_tick_t;
  atsq_tick_t st_r, st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (!resetn) begin
      st_nxt = '0;
    end else if (st_r.cnt == LAST) begin
      st_nxt.cnt = '0; // R23
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign tick = st_r.tick;

  a_tick_single_cycle: assert property (@(posedge clk) disable iff (!resetn)
    st_r.tick |=> !st_r.tick) else $error("Timebase tick too long.");
endmodule // atsq_tick

// File: atsq_pulse.sv
// Stretches each fire request into a fixed-width output pulse.
`timescale 1ns/100ps
module atsq_pulse
  import atsq_pkg::*;
#(
  parameter int WIDTH_CYC = PULSE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  atsq_fire_if.pulser fif
);
  localparam int CW = $clog2(WIDTH_CYC + 1);
  localparam logic [CW-1:0] LOAD = CW'(WIDTH_CYC);
  typedef struct packed {
    logic [OUT_LINES-1:0][CW-1:0] cnt;
    logic [OUT_LINES-1:0] level;
  } atsq_pulse_t;
  atsq_pulse_t st_r, st_nxt;

  // A new request restarts the pulse rather than being lost in it.
  always_comb begin
    st_nxt = st_r;
    for (int k = 0; k < OUT_LINES; k++) begin
      if (fif.fire[k]) begin
        st_nxt.cnt[k] = LOAD; // R21
      end else if (st_r.cnt[k] != '0) begin
        st_nxt.cnt[k] = st_r.cnt[k] - 1'b1;
      end
      st_nxt.level[k] = (st_nxt.cnt[k] != '0);
    end
    if (!resetn) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign fif.level = st_r.level;

  a_pulse_starts_high: assert property (@(posedge clk) disable iff (!resetn)
    fif.fire[0] |=> fif.level[0]) else $error("Pulse did not start."); // R21
endmodule // atsq_pulse

// File: atsq_action_partner.sv
// Far-side model that finishes each source and measure action.
`timescale 1ns/100ps
module atsq_action_partner #(
  parameter int SRC_LAT = 3,
  parameter int MEAS_LAT = 5
) (
  input wire logic clk,
  input wire logic sourceApply,
  input wire logic measureStart,
  output logic sourceDone = 1'b0,
  output logic measureDone = 1'b0
);
  int srcCnt = 0;
  int measCnt = 0;
  // Each done is a single pulse, some cycles after its start request.
  always @(posedge clk) begin
    sourceDone <= (srcCnt == 1);
    measureDone <= (measCnt == 1);
    if (sourceApply === 1'b1) srcCnt <= SRC_LAT;
    else if (srcCnt > 0) srcCnt <= srcCnt - 1;
    if (measureStart === 1'b1) measCnt <= MEAS_LAT;
    else if (measCnt > 0) measCnt <= measCnt - 1;
  end
endmodule // atsq_action_partner

// File: atsq_arm_trigger_sequencer_tb.sv
// Self-checking bench of the arm/trigger sequencer.
`timescale 1ns/100ps
module atsq_arm_trigger_sequencer_tb;
  import atsq_pkg::*;
  logic clk = 0;
  logic resetn = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wrData = 32'h0000_0000;
  logic wrStrobe = 0;
  logic rdStrobe = 0;
  logic busTrig = 0;
  logic chanSecond = 0;
  logic peerSourced = 0;
  logic [DIO_LINES-1:0] dioIn = '0;
  logic [31:0] rdData, rv;
  logic sourceDone, measureDone, sourceApply, measureStart;
  logic sourceHeld, lanTrigOut;
  logic [1:0] intLineOut;
  logic [DIO_LINES-1:0] dioOut, dioOeN;
  int miscompares = 0;
  int checked = 0;
  int nSrc = 0;
  int nMeas = 0;
  int nLan = 0;
  int nLine = 0;
  int base = 0;
  time t0;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    nSrc <= nSrc + int'(sourceApply);
    nMeas <= nMeas + int'(measureStart);
    nLan <= nLan + int'(lanTrigOut);
    nLine <= nLine + int'(|{intLineOut, dioOut});
  end
  atsq_arm_trigger_sequencer #(.PULSE_CYCLES(4))
    atsq_arm_trigger_sequencer_inst (
    .clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData),
    .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData),
    .busTrig(busTrig), .lanTrigIn(1'b0), .intLineIn(2'b00),
    .dioIn(dioIn), .sourceDone(sourceDone), .measureDone(measureDone),
    .chanSecond(chanSecond), .peerSourced(peerSourced),
    .sourceApply(sourceApply),
    .measureStart(measureStart), .sourceHeld(sourceHeld),
    .intLineOut(intLineOut), .lanTrigOut(lanTrigOut), .dioOut(dioOut),
    .dioOeN(dioOeN));
  atsq_action_partner atsq_action_partner_inst (
    .clk(clk), .sourceApply(sourceApply), .measureStart(measureStart),
    .sourceDone(sourceDone), .measureDone(measureDone));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    #1;
    d = rdData;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 300; i++) begin
      rd(OFS_STATUS, rv);
      if (rv[6:0] === 7'h00) return;
    end
    check(rv, 32'h0000_0000);
  endtask
  task automatic stop_test();
    $display("Mismatches %0d of %0d checks", miscompares, checked);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rd(8'h24, rv);
    check(rv, {16'h0000, COUNT_RST});
    rd(8'h3C, rv);
    check(rv, {26'h0, TIMING_RST});
    rd(8'hF0, rv);
    check(rv, 32'h0000_0000);
    check(dioOeN, 14'h3FFF);
    // Two arms of two triggers; trigger out on LAN at action entry only.
    wr(8'h44, 32'h0000_0002);
    wr(8'h48, 32'h0000_0002);
    wr(8'h5C, 32'h0002_0410);
    wr(OFS_CTRL, 32'h0000_0002);
    wait_idle();
    check(nMeas, 4);
    check(nSrc, 0);
    check(nLan, 4 * 4);
    check(nLine, 0);
    // Source sequencer waits on the bus for both arm and trigger.
    wr(8'h20, 32'h0000_0101);
    wr(OFS_CTRL, 32'h0000_0041);
    repeat (30) @(posedge clk);
    rd(OFS_STATUS, rv);
    check(rv[2:0], 3'h1);
    @(posedge clk);
    busTrig <= 1'b1;
    @(posedge clk);
    busTrig <= 1'b0;
    repeat (10) @(posedge clk);
    rd(OFS_STATUS, rv);
    check(rv[2:0], 3'h3);
    check(nSrc, 0);
    @(posedge clk);
    busTrig <= 1'b1;
    @(posedge clk);
    busTrig <= 1'b0;
    wait_idle();
    check(nSrc, 1);
    // Abort a sequencer left waiting for an arm event.
    wr(OFS_CTRL, 32'h0000_0001);
    repeat (10) @(posedge clk);
    wr(OFS_CTRL, 32'h0000_0004);
    rd(OFS_STATUS, rv);
    check(rv[2:0], 3'h0);
    // Grouped second channel holds its source until the peer has sourced.
    wr(8'h20, 32'h0000_0000);
    chanSecond <= 1'b1;
    wr(OFS_CTRL, 32'h0000_0011);
    repeat (20) @(posedge clk);
    rd(OFS_STATUS, rv);
    check(rv[2:0], 3'h6);
    check(nSrc, 1);
    @(posedge clk);
    peerSourced <= 1'b1;
    repeat (20) @(posedge clk);
    check(sourceHeld, 1'b1);
    check(nSrc, 2);
    wr(OFS_CTRL, 32'h0000_0004);
    wait_idle();
    check(sourceHeld, 1'b0);
    // Timer source with an arm delay: the run cannot finish early.
    wr(8'h44, 32'h0000_0001);
    wr(8'h48, 32'h0000_0003);
    wr(8'h4C, 32'h0000_0003);
    wr(8'h58, 32'h0000_0002);
    wr(8'h40, 32'h0000_0200);
    base = nMeas;
    t0 = $time;
    wr(OFS_CTRL, 32'h0000_0002);
    wait_idle();
    check(nMeas - base, 3);
    check(32'(($time - t0) / 20 >= 6 * TICK_CYC), 32'h1);
    // A rising edge on the first DIGITAL_IO_PORT line triggers one measurement.
    wr(8'h48, 32'h0000_0001);
    wr(8'h40, 32'h0000_0600);
    wr(8'h5C, 32'h0003_0410);
    base = nMeas;
    wr(OFS_CTRL, 32'h0000_0002);
    check(dioOeN, 14'h3FFE);
    repeat (300) @(posedge clk);
    dioIn <= 14'h0001;
    wait_idle();
    check(nMeas - base, 1);
    check(nLine, 4);
    // Automatic mode with output on measures while source stays idle.
    base = nMeas;
    wr(OFS_CTRL, 32'h0000_0028);
    rd(OFS_CTRL, rv);
    check(rv, 32'h0000_0028);
    repeat (300) @(posedge clk);
    check(32'(nMeas - base > 3), 32'h1);
    check(nSrc, 2);
    wr(OFS_CTRL, 32'h0000_0004);
    wait_idle();
    stop_test();
  end
endmodule // atsq_arm_trigger_sequencer_tb
